// [verilog/cbt_params.svh]
`ifndef CBT_PARAMS_SVH
`define CBT_PARAMS_SVH
`define CBT_OFF_MASK0        12'h000
`define CBT_OFF_MASK1        12'h004
`define CBT_OFF_MASK2        12'h008
`define CBT_OFF_FMSKSEL      12'h00c
`define CBT_OFF_FUL_LO       12'h010
`define CBT_OFF_FUL_HI       12'h014
`define CBT_OFF_OVF_LO       12'h018
`define CBT_OFF_OVF_HI       12'h01c
`define CBT_OFF_CON01        12'h020
`define CBT_OFF_CON23        12'h024
`define CBT_OFF_CON45        12'h028
`define CBT_OFF_CON67        12'h02c
`define CBT_OFF_IRQ_STAT     12'h030
`define CBT_OFF_IRQ_MASK     12'h034
`define CBT_OFF_FILT_ID      12'h038
`define CBT_CON_DIR_BIT      7
`define CBT_CON_ABT_BIT      6
`define CBT_CON_LARB_BIT     5
`define CBT_CON_ERR_BIT      4
`define CBT_CON_REQ_BIT      3
`define CBT_CON_RTR_BIT      2
`define CBT_CON_RESET        16'h0000
`define CBT_FLAG_RESET       16'h0000
`define CBT_MASK_NONE        2'h3
`define CBT_IRQ_RX_BUFFER_FULL_FLAG        0
`define CBT_IRQ_RX_BUFFER_OVERFLOW_FLAG        1
`define CBT_IRQ_TXDONE       2
`define CBT_IRQ_TXFAIL       3
`endif

// [verilog/cbt_pkg.sv]
package cbt_pkg;
  typedef struct packed {
    logic       dir;
    logic       aborted;
    logic       lost_arb;
    logic       bus_err;
    logic       send_req;
    logic       rtr_en;
    logic [1:0] prio;
  } cbt_ctrl_s;

  typedef struct packed {
    logic       done;
    logic       abort_ack;
    logic       lost_arb;
    logic       bus_err;
    logic [2:0] buf_idx;
  } cbt_txres_s;

  typedef enum logic [2:0] {
    CBT_IDLE = 3'b001,
    CBT_BUSY = 3'b010,
    CBT_WAIT = 3'b100
  } cbt_tx_e;
endpackage

// [verilog/cbt_tx_arbiter.sv]
// Picks the pending transmit buffer of highest priority; ties go to the higher index.
module cbt_tx_arbiter (
  input  wire logic [7:0]       pend,
  input  wire logic [15:0]      prio,
  output logic                  any,
  output logic [2:0]            sel
);
  logic [2:0] best_idx;
  logic [1:0] best_pri;
  logic       found;
  always_comb begin
    best_idx = 3'h0;
    best_pri = 2'h0;
    found    = 1'b0;
    for (int i = 0; i < 8; i++) begin
      // Ascending scan with >= lets the higher index win a tie.
      if (pend[i] && (!found || prio[2*i +: 2] >= best_pri)) begin
        best_idx = i[2:0];
        best_pri = prio[2*i +: 2];
        found    = 1'b1;
      end
    end
    any = found;
    sel = best_idx;
  end
endmodule

// [verilog/cbt_filter_match.sv]
// One acceptance filter compare against the mask chosen by its two-bit source field.
module cbt_filter_match (
  input  wire logic [15:0] msg_id,
  input  wire logic [15:0] filt_id,
  input  wire logic [1:0]  mask_src,
  input  wire logic [47:0] masks,
  output logic             hit
);
  logic [15:0] eff_mask;
  always_comb begin
    case (mask_src)
      2'h0:    eff_mask = masks[15:0];
      2'h1:    eff_mask = masks[31:16];
      2'h2:    eff_mask = masks[47:32];
      default: eff_mask = 16'h0000;
    endcase
    // Only bits whose mask bit is set take part in the compare.
    hit = ((msg_id ^ filt_id) & eff_mask) == 16'h0000;
  end
endmodule

// [verilog/cbt_core.sv]
// Operation
// - Set mask bits compare identifier bits; clear bits are don't-care.
// - Filter mask source 00/01/10 selects mask 0/1/2; 11 means no mask.
// - Storing a received message sets that buffer's full flag; reset clears.
// - Storing into a still-full buffer sets its overflow flag.
// - Each control register: upper byte odd buffer, lower byte even buffer.
// - Direction bit set means transmit buffer, clear means receive buffer.
// - Aborted status set when a transmission was aborted; read-only.
// - Lost-arbitration status set when the message lost arbitration; read-only.
// - Bus-error status set on bus error during sending; read-only.
// - Send request starts transmission; hardware clears it after success.
// - Software clearing a set send request asks for an abort.
// - With auto reply enabled, a matching remote request sets send request.
// - Two-bit priority orders pending sends, 11 highest, 00 lowest.
// - Setting send request clears aborted, lost-arbitration and bus-error bits.
//
// Our own choices: the APB interface to the registers and the register offsets.
`include "cbt_params.svh"
module cbt_core (
  input  wire logic                mclk,
  input  wire logic                rst,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [11:0]         paddr,
  input  wire logic [31:0]         pwdata,
  output logic [31:0]              prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire logic                rx_store,
  input  wire logic [4:0]          rx_buf_idx,
  input  wire logic                rx_id_valid,
  input  wire logic [15:0]         rx_msg_id,
  input  wire logic                rx_remote_req,
  input  wire logic [2:0]          rx_remote_buf,
  output logic                     rx_accept,
  output logic                     tx_start,
  output logic [2:0]               tx_buf_idx,
  output logic                     tx_abort,
  input  wire cbt_pkg::cbt_txres_s tx_result,
  input  wire logic                tx_result_valid,
  output logic                     irq
);
  // Message contents stay in DMA memory; only bookkeeping is held here.
  logic [47:0]             mask_reg;
  logic [15:0]             fmsksel_reg;
  logic [15:0]             filt_id_reg;
  logic [31:0]             full_reg;
  logic [31:0]             ovf_reg;
  cbt_pkg::cbt_ctrl_s      ctrl_reg [8];
  logic [3:0]              irq_stat_reg;
  logic [3:0]              irq_mask_reg;
  cbt_pkg::cbt_tx_e        tx_state_reg;
  logic [2:0]              tx_buf_reg;
  logic                    tx_start_reg;
  logic                    tx_abort_reg;
  logic [31:0]             prdata_reg;
  logic [31:0]             full_next;
  logic [31:0]             ovf_next;
  logic [3:0]              irq_events;
  logic                    wr;
  logic                    rd;
  logic                    mapped;
  logic [31:0]             rd_val;
  logic [7:0]              pend;
  logic [15:0]             prio_vec;
  logic                    arb_any;
  logic [2:0]              arb_sel;
  logic [7:0]              filt_hits;
  logic [31:0]             store_bit;

  assign wr      = psel && penable && pwrite;
  assign rd      = psel && penable && !pwrite;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign prdata  = prdata_reg;
  assign irq     = |(irq_stat_reg & irq_mask_reg);
  assign tx_start   = tx_start_reg;
  assign tx_abort   = tx_abort_reg;
  assign tx_buf_idx = tx_buf_reg;
  assign store_bit  = rx_store ? (32'h0000_0001 << rx_buf_idx) : 32'h0000_0000;

  // Eight filters share one identifier word and differ only by their mask source.
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : gen_filt
      cbt_filter_match u_match (
        .msg_id   (rx_msg_id),
        .filt_id  (filt_id_reg),
        .mask_src (fmsksel_reg[2*g +: 2]),
        .masks    (mask_reg),
        .hit      (filt_hits[g])
      );
      assign pend[g]            = ctrl_reg[g].dir && ctrl_reg[g].send_req;
      assign prio_vec[2*g +: 2] = ctrl_reg[g].prio;
    end
  endgenerate
  assign rx_accept = rx_id_valid && (|filt_hits);

  cbt_tx_arbiter u_arb (
    .pend (pend),
    .prio (prio_vec),
    .any  (arb_any),
    .sel  (arb_sel)
  );

  always_comb begin
    mapped = 1'b1;
    rd_val = 32'h0000_0000;
    case (paddr)
      `CBT_OFF_MASK0:    rd_val = {16'h0000, mask_reg[15:0]};
      `CBT_OFF_MASK1:    rd_val = {16'h0000, mask_reg[31:16]};
      `CBT_OFF_MASK2:    rd_val = {16'h0000, mask_reg[47:32]};
      `CBT_OFF_FMSKSEL:  rd_val = {16'h0000, fmsksel_reg};
      `CBT_OFF_FILT_ID:  rd_val = {16'h0000, filt_id_reg};
      `CBT_OFF_FUL_LO:   rd_val = {16'h0000, full_reg[15:0]};
      `CBT_OFF_FUL_HI:   rd_val = {16'h0000, full_reg[31:16]};
      `CBT_OFF_OVF_LO:   rd_val = {16'h0000, ovf_reg[15:0]};
      `CBT_OFF_OVF_HI:   rd_val = {16'h0000, ovf_reg[31:16]};
      `CBT_OFF_CON01:    rd_val = {16'h0000, ctrl_reg[1], ctrl_reg[0]};
      `CBT_OFF_CON23:    rd_val = {16'h0000, ctrl_reg[3], ctrl_reg[2]};
      `CBT_OFF_CON45:    rd_val = {16'h0000, ctrl_reg[5], ctrl_reg[4]};
      `CBT_OFF_CON67:    rd_val = {16'h0000, ctrl_reg[7], ctrl_reg[6]};
      `CBT_OFF_IRQ_STAT: rd_val = {28'h0000000, irq_stat_reg};
      `CBT_OFF_IRQ_MASK: rd_val = {28'h0000000, irq_mask_reg};
      default:           mapped = 1'b0;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      prdata_reg <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata_reg <= rd_val;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      mask_reg    <= 48'h0;
      fmsksel_reg <= 16'h0000;
      filt_id_reg <= 16'h0000;
      irq_mask_reg <= 4'h0;
    end else if (wr) begin
      case (paddr)
        `CBT_OFF_MASK0:    mask_reg[15:0]  <= pwdata[15:0];
        `CBT_OFF_MASK1:    mask_reg[31:16] <= pwdata[15:0];
        `CBT_OFF_MASK2:    mask_reg[47:32] <= pwdata[15:0];
        `CBT_OFF_FMSKSEL:  fmsksel_reg     <= pwdata[15:0];
        `CBT_OFF_FILT_ID:  filt_id_reg     <= pwdata[15:0];
        `CBT_OFF_IRQ_MASK: irq_mask_reg    <= pwdata[3:0];
        default: ;
      endcase
    end
  end

  // Flags: software writes zero to clear, a one is ignored, and a store in the same
  // cycle wins over the clear so no received message goes unreported.
  always_comb begin
    full_next = full_reg;
    ovf_next  = ovf_reg;
    if (wr) begin
      case (paddr)
        `CBT_OFF_FUL_LO: full_next[15:0]  = full_reg[15:0] & pwdata[15:0];
        `CBT_OFF_FUL_HI: full_next[31:16] = full_reg[31:16] & pwdata[15:0];
        `CBT_OFF_OVF_LO: ovf_next[15:0]   = ovf_reg[15:0] & pwdata[15:0];
        `CBT_OFF_OVF_HI: ovf_next[31:16]  = ovf_reg[31:16] & pwdata[15:0];
        default: ;
      endcase
    end
    full_next = full_next | store_bit;
    ovf_next  = ovf_next | (store_bit & full_reg);
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      full_reg <= {`CBT_FLAG_RESET, `CBT_FLAG_RESET};
      ovf_reg  <= 32'h0000_0000;
    end else begin
      full_reg <= full_next;
      ovf_reg  <= ovf_next;
    end
  end

  // Control registers, one generate entry per buffer.
  generate
    for (g = 0; g < 8; g++) begin : gen_ctrl
      logic [7:0] wbyte;
      logic       sel_w;
      logic       hw_done;
      logic       hw_fail;
      logic       sw_set;
      logic       rtr_set;
      assign sel_w = wr && (paddr == (`CBT_OFF_CON01 + 12'(4 * (g / 2))));
      assign wbyte = (g % 2 == 1) ? pwdata[15:8] : pwdata[7:0];
      assign hw_done = tx_result_valid && tx_result.buf_idx == 3'(g) && tx_result.done;
      assign hw_fail = tx_result_valid && tx_result.buf_idx == 3'(g) && !tx_result.done;
      assign sw_set  = sel_w && wbyte[`CBT_CON_REQ_BIT] && !ctrl_reg[g].send_req;
      assign rtr_set = rx_remote_req && rx_remote_buf == 3'(g) && ctrl_reg[g].rtr_en
                       && ctrl_reg[g].dir;
      always_ff @(posedge mclk) begin
        if (rst) begin
          ctrl_reg[g] <= 8'(`CBT_CON_RESET);
        end else begin
          if (sel_w) begin
            // Status bits are read-only and ignore the write.
            ctrl_reg[g].dir      <= wbyte[`CBT_CON_DIR_BIT];
            ctrl_reg[g].rtr_en   <= wbyte[`CBT_CON_RTR_BIT];
            ctrl_reg[g].prio     <= wbyte[1:0];
            ctrl_reg[g].send_req <= wbyte[`CBT_CON_REQ_BIT];
          end
          if (hw_done) begin
            ctrl_reg[g].send_req <= 1'b0;
            ctrl_reg[g].aborted  <= 1'b0;
          end
          if (hw_fail) begin
            ctrl_reg[g].aborted  <= tx_result.abort_ack;
            ctrl_reg[g].lost_arb <= tx_result.lost_arb;
            ctrl_reg[g].bus_err  <= tx_result.bus_err;
            if (tx_result.abort_ack) begin
              ctrl_reg[g].send_req <= 1'b0;
            end
          end
          if (sw_set || rtr_set) begin
            ctrl_reg[g].send_req <= 1'b1;
            ctrl_reg[g].aborted  <= 1'b0;
            ctrl_reg[g].lost_arb <= 1'b0;
            ctrl_reg[g].bus_err  <= 1'b0;
          end
        end
      end
    end
  endgenerate

  // Transmit sequencing: one message in flight; the engine reports every outcome.
  always_ff @(posedge mclk) begin
    if (rst) begin
      tx_state_reg <= cbt_pkg::CBT_IDLE;
      tx_buf_reg   <= 3'h0;
      tx_start_reg <= 1'b0;
      tx_abort_reg <= 1'b0;
    end else begin
      tx_start_reg <= 1'b0;
      tx_abort_reg <= 1'b0;
      case (tx_state_reg)
        cbt_pkg::CBT_IDLE: begin
          if (arb_any) begin
            tx_buf_reg   <= arb_sel;
            tx_start_reg <= 1'b1;
            tx_state_reg <= cbt_pkg::CBT_BUSY;
          end
        end
        cbt_pkg::CBT_BUSY: begin
          if (tx_result_valid) begin
            tx_state_reg <= cbt_pkg::CBT_IDLE;
          end else if (!ctrl_reg[tx_buf_reg].send_req) begin
            tx_abort_reg <= 1'b1;
            tx_state_reg <= cbt_pkg::CBT_WAIT;
          end
        end
        cbt_pkg::CBT_WAIT: begin
          if (tx_result_valid) begin
            tx_state_reg <= cbt_pkg::CBT_IDLE;
          end
        end
        default: tx_state_reg <= cbt_pkg::CBT_IDLE;
      endcase
    end
  end

  // One sticky cause per event; an abort outcome counts as a failed send.
  assign irq_events[`CBT_IRQ_RX_BUFFER_FULL_FLAG]  = rx_store;
  assign irq_events[`CBT_IRQ_RX_BUFFER_OVERFLOW_FLAG]  = |(store_bit & full_reg);
  assign irq_events[`CBT_IRQ_TXDONE] = tx_result_valid && tx_result.done;
  assign irq_events[`CBT_IRQ_TXFAIL] = tx_result_valid && !tx_result.done;

  always_ff @(posedge mclk) begin
    if (rst) begin
      irq_stat_reg <= 4'h0;
    end else begin
      if (wr && paddr == `CBT_OFF_IRQ_STAT) begin
        irq_stat_reg <= (irq_stat_reg & ~pwdata[3:0]) | irq_events;
      end else begin
        irq_stat_reg <= irq_stat_reg | irq_events;
      end
    end
  end
endmodule

// [verification/cbt_sva.sv]
module cbt_sva (
  input wire logic        mclk,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        rx_store,
  input wire logic        tx_start,
  input wire logic        tx_abort,
  input wire logic        tx_result_valid,
  input wire logic        irq
);
  timeunit 1ns;
  timeprecision 1ns;
  // High while the engine still owes an answer, so starts and aborts can be judged.
  logic busy_reg;
  logic acc;
  assign acc = psel && penable;
  always_ff @(posedge mclk) begin
    if (rst) begin
      busy_reg <= 1'b0;
    end else if (tx_start) begin
      busy_reg <= 1'b1;
    end else if (tx_result_valid) begin
      busy_reg <= 1'b0;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  ready_always_a:
    assert property (acc |-> pready) else $error("ready low in access");
  unmapped_err_a:
    assert property (acc && paddr > 12'h038 |-> pslverr) else $error("no unmapped error");
  reset_quiet_a:
    assert property ($fell(rst) |-> !irq && !tx_start && !tx_abort)
    else $error("outputs active after reset");
  single_flight_a:
    assert property (tx_start |-> !busy_reg) else $error("second start in flight");
  abort_busy_a:
    assert property (tx_abort |-> busy_reg) else $error("abort while idle");
  req_starts_a:
    assert property (acc && pwrite && paddr == 12'h020 && pwdata[7] && pwdata[3]
      && !busy_reg && !tx_start && !tx_result_valid |-> ##[1:3] tx_start)
    else $error("send request not started");
  irq_mask_off_a:
    assert property (acc && pwrite && paddr == 12'h034 && pwdata[3:0] == 4'h0 |=> !irq)
    else $error("irq with mask cleared");
  irq_clear_a:
    assert property (acc && pwrite && paddr == 12'h030 && pwdata[3:0] == 4'hf
      && !rx_store && !tx_result_valid && !$past(tx_result_valid) |=> !irq)
    else $error("irq after status clear");
endmodule
bind cbt_core cbt_sva chk (.mclk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
  .pready, .pslverr, .rx_store, .tx_start, .tx_abort, .tx_result_valid, .irq);

// [verification/cbt_tx_engine.sv]
module cbt_tx_engine (
  input  wire logic           mclk,
  input  wire logic           rst,
  input  wire logic           tx_start,
  input  wire logic [2:0]     tx_buf_idx,
  input  wire logic           tx_abort,
  input  wire logic [2:0]     mode,
  input  wire logic [7:0]     delay,
  output cbt_pkg::cbt_txres_s tx_result,
  output logic                tx_result_valid
);
  timeunit 1ns;
  timeprecision 1ns;
  logic       busy;
  logic [7:0] cnt;
  logic [2:0] idx;
  // Mode bit 2 keeps the frame on the bus until an abort; bits 1:0 report bus error
  // and lost arbitration. Between results the lines toggle so stale values never help.
  always_ff @(posedge mclk) begin
    tx_result_valid <= 1'b0;
    tx_result       <= ~tx_result;
    if (rst) begin
      busy      <= 1'b0;
      tx_result <= '0;
    end else if (tx_start) begin
      busy <= 1'b1;
      cnt  <= delay;
      idx  <= tx_buf_idx;
    end else if (busy && (tx_abort || (!mode[2] && cnt == 8'h00))) begin
      busy            <= 1'b0;
      tx_result_valid <= 1'b1;
      tx_result       <= {mode[1:0] == 2'h0 && !tx_abort, tx_abort,
                          mode[0] && !tx_abort, mode[1] && !tx_abort, idx};
    end else if (busy) begin
      cnt <= cnt - 8'h01;
    end
  end
endmodule

// [verification/tb_top.sv]
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        mclk, rst, psel, penable, pwrite, rx_store, rx_id_valid, rx_remote_req;
  logic        pready, pslverr, rx_accept, tx_start, tx_abort, irq, tx_result_valid, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] rx_msg_id, lfsr, r;
  logic [4:0]  rx_buf_idx;
  logic [2:0]  rx_remote_buf, tx_buf_idx, mode;
  logic [7:0]  delay;
  int          err_count, samples_checked;
  int          cycles = 0;
  cbt_pkg::cbt_txres_s tx_result;
  cbt_core uut (.mclk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .rx_store, .rx_buf_idx, .rx_id_valid, .rx_msg_id, .rx_remote_req,
    .rx_remote_buf, .rx_accept, .tx_start, .tx_buf_idx, .tx_abort, .tx_result,
    .tx_result_valid, .irq);
  cbt_tx_engine pm (.mclk, .rst, .tx_start, .tx_buf_idx, .tx_abort, .mode, .delay,
    .tx_result, .tx_result_valid);
  always #20 mclk = ~mclk;
  function automatic logic [15:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr;
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("checks=%0d mismatches=%0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  task automatic pulse(input logic rem, input logic [4:0] i);
    @(posedge mclk);
    rx_store      <= !rem;
    rx_remote_req <= rem;
    rx_buf_idx    <= i;
    rx_remote_buf <= i[2:0];
    @(posedge mclk);
    rx_store      <= 1'b0;
    rx_remote_req <= 1'b0;
  endtask
  task automatic twait(input logic st);
    int n;
    n = 0;
    do begin
      @(negedge mclk);
      n++;
    end while ((st ? tx_start : tx_result_valid) !== 1'b1 && n < 80);
  endtask
  task automatic irqw(input logic [11:0] a, input logic [31:0] d, input logic e);
    if (a != 12'h0) apb(1'b1, a, d);
    @(negedge mclk);
    chk(irq, e);
  endtask
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      close_out();
    end
  end
  initial begin
    {mclk, psel, penable, pwrite, rx_store, rx_id_valid, rx_remote_req} = '0;
    {paddr, pwdata, rx_msg_id, rx_buf_idx, rx_remote_buf, mode} = '0;
    rst = 1'b1;
    delay = 8'h03;
    lfsr = 16'h0036;
    err_count = 0;
    samples_checked = 0;
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    for (int a = 12; a <= 52; a += 4) rdchk(12'(a), 32'h0);
    rdchk(12'h03c, 32'h0);
    chk(err, 1'b1);
    r = rnd();
    apb(1'b1, 12'h008, {16'h0, r});
    rdchk(12'h008, {16'h0, r});
    apb(1'b1, 12'h038, 32'h1234);
    for (int c = 0; c < 4; c++) begin
      for (int m = 0; m < 3; m++) apb(1'b1, 12'(4 * m), m == c ? 32'hff00 : 32'h0);
      apb(1'b1, 12'h00c, {16'h0, {8{2'(c)}}});
      rx_id_valid <= 1'b1;
      rx_msg_id   <= 16'h1200 | (rnd() & 16'h00ff);
      @(negedge mclk);
      chk(rx_accept, 1'b1);
      @(posedge mclk);
      rx_msg_id <= 16'h1300 | (rnd() & 16'h00ff);
      @(negedge mclk);
      chk(rx_accept, c == 3);
    end
    for (int k = 0; k < 2; k++) begin
      logic [4:0]  i;
      logic [11:0] fa;
      logic [31:0] b;
      i = 5'(rnd());
      i[4] = k[0];
      fa = k[0] ? 12'h014 : 12'h010;
      b = 32'h1 << i[3:0];
      pulse(1'b0, i);
      rdchk(fa, b);
      pulse(1'b0, i);
      rdchk(fa + 12'h008, b);
      apb(1'b1, fa, 32'hffff);
      rdchk(fa, b);
      apb(1'b1, fa, {16'h0, ~b[15:0]});
      apb(1'b1, fa + 12'h008, {16'h0, ~b[15:0]});
      rdchk(fa, 32'h0);
      rdchk(fa + 12'h008, 32'h0);
    end
    delay <= 8'(rnd() & 16'h0007);
    apb(1'b1, 12'h020, 32'h8b8b);
    twait(1'b1);
    chk(tx_buf_idx, 3'h1);
    twait(1'b0);
    twait(1'b1);
    chk(tx_buf_idx, 3'h0);
    twait(1'b0);
    rdchk(12'h020, 32'h8383);
    apb(1'b1, 12'h024, 32'h898a);
    twait(1'b1);
    chk(tx_buf_idx, 3'h2);
    twait(1'b0);
    twait(1'b1);
    chk(tx_buf_idx, 3'h3);
    twait(1'b0);
    mode <= 3'h3;
    apb(1'b1, 12'h028, 32'h0088);
    twait(1'b0);
    twait(1'b0);
    mode <= 3'h4;
    rdchk(12'h028, 32'h00b8);
    apb(1'b1, 12'h028, 32'h0080);
    twait(1'b0);
    rdchk(12'h028, 32'h00c0);
    apb(1'b1, 12'h028, 32'h00f8);
    rdchk(12'h028, 32'h0088);
    apb(1'b1, 12'h028, 32'h0080);
    twait(1'b0);
    rdchk(12'h028, 32'h00c0);
    mode <= 3'h0;
    delay <= 8'h40;
    apb(1'b1, 12'h02c, 32'h8084);
    pulse(1'b1, 5'd6);
    twait(1'b1);
    chk(tx_buf_idx, 3'h6);
    twait(1'b0);
    pulse(1'b1, 5'd7);
    rdchk(12'h02c, 32'h8084);
    irqw(12'h030, 32'hf, 1'b0);
    irqw(12'h034, 32'h1, 1'b0);
    pulse(1'b0, 5'd9);
    irqw(12'h000, 32'h0, 1'b1);
    irqw(12'h034, 32'h0, 1'b0);
    irqw(12'h034, 32'h1, 1'b1);
    irqw(12'h030, 32'h1, 1'b0);
    close_out();
  end
endmodule
